// ===== design/rirc_pkg.sv
// Constants shared by the reset, interrupt-pin and periodic-timer control block.
package rirc_pkg;
  // Register map, byte offsets on the plain register port.
  localparam logic [7:0] PIN_CTL_ADDR  = 8'h00;
  localparam logic [7:0] RST_STAT_ADDR = 8'h01;
  localparam logic [7:0] RTI_CTL_ADDR  = 8'h02;
  localparam logic [7:0] PWR_CTL1_ADDR = 8'h03;
  localparam logic [7:0] PWR_CTL2_ADDR = 8'h04;
  localparam logic [7:0] SYS_OPT_ADDR  = 8'h05;
  // Pin interrupt status and control fields.
  localparam int PIN_POL_BIT  = 5;
  localparam int PIN_EN_BIT   = 4;
  localparam int PIN_FLAG_BIT = 3;
  localparam int PIN_ACK_BIT  = 2;
  localparam int PIN_IE_BIT   = 1;
  localparam int PIN_MODE_BIT = 0;
  // Reset source status fields.
  localparam int RST_POR_BIT  = 7;
  localparam int RST_PIN_BIT  = 6;
  localparam int RST_WDG_BIT  = 5;
  localparam int RST_OPC_BIT  = 4;
  localparam int RST_CLK_BIT  = 2;
  localparam int RST_LV_BIT   = 1;
  localparam logic [7:0] RST_STAT_POR_VAL = 8'h82;
  // Periodic timer status and control fields.
  localparam int RTI_FLAG_BIT = 7;
  localparam int RTI_ACK_BIT  = 6;
  localparam int RTI_CLKS_BIT = 5;
  localparam int RTI_IE_BIT   = 4;
  // Power control 1 and 2 fields.
  localparam int LV_FLAG_BIT  = 7;
  localparam int LV_ACK_BIT   = 6;
  localparam int LV_IE_BIT    = 5;
  localparam int LV_RE_BIT    = 4;
  localparam int LV_DE_BIT    = 3;
  localparam int WARN_BIT     = 7;
  localparam int LV_SE_BIT    = 5;
  localparam int LV_TRIP_BIT  = 4;
  localparam int WARN_TRIP_BIT = 3;
  localparam logic [7:0] PWR_CTL1_RST = 8'h18;
  localparam logic [7:0] PWR_CTL2_RST = 8'h00;
  // System options fields, write-once.
  localparam int OPT_WDG_BIT  = 7;
  localparam int OPT_STOP_BIT = 5;
  localparam int OPT_BDM_BIT  = 4;
  localparam logic [7:0] SYS_OPT_RST = 8'h80;
  // Address gaps whose access forces a reset.
  localparam logic [15:0] GAP1_LO = 16'h0440;
  localparam logic [15:0] GAP1_HI = 16'h17FF;
  localparam logic [15:0] GAP2_LO = 16'h1834;
  localparam logic [15:0] GAP2_HI = 16'hBFFF;
  // Internal timer tick, 1 ms nominal, on a 100 ns bus clock.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int INT_TICK_NS     = 1000000;
  localparam int INT_TICK_CYCLES = INT_TICK_NS / CLK_PERIOD_NS;
  // Operating modes seen by the block.
  typedef enum logic [3:0] {
    RIRC_RUN   = 4'b0001,
    RIRC_STOP1 = 4'b0010,
    RIRC_STOP2 = 4'b0100,
    RIRC_STOP3 = 4'b1000
  } rirc_mode_e;
endpackage

// ===== design/rirc_top.sv
// Reset source capture, undervoltage control, interrupt pin and periodic timer.
//
// Functional notes
// - Power-on sets power-on and low-voltage flags; reset held until supply above low trip.
// - With reset enable set, low voltage resets and holds until above selected trip.
// - In interrupt configuration low voltage sets its flag and raises an interrupt.
// - Supply warning flag with selectable trip level, never an interrupt.
// - Timer uses reference clock in run, internal in stop2, either in stop3, none in stop1.
// - Period select zero holds the timer counter clear, so no timeouts occur.
// - Timeout sets the flag; interrupt only when the local enable is set.
// - Codes one to seven give 8..1024 internal ticks or 256..32768 reference periods.
// - Writing 1 to the timer acknowledge clears its flag; it reads 0.
// - Polarity 1 means rising edges or high levels, 0 falling or low.
// - Pin enabled with rising polarity selects a pull-down instead of pull-up.
// - The pin raises new events only while its enable is set; a flag already set still requests.
// - A qualifying pin event sets a read-only event flag.
// - Writing 1 to the pin acknowledge clears the flag; 0 does nothing; reads 0.
// - In edge-and-level mode the acknowledge fails while the pin stays asserted.
// - Pin interrupt enable passes the event flag as a hardware request.
// - Detection mode 1 catches edges and levels, 0 only edges.
// - Status holds power-on, pin, watchdog, opcode, clock module, low-voltage flags.
// - A debug-forced reset leaves every status flag clear.
// - Any write to the status address restarts the watchdog, contents unchanged.
// - Low-voltage reset keeps power-on flag; other resets flag only active sources.
// - Bad opcode, disallowed stop or background instruction force a reset.
// - Accesses within the two address gaps force a reset.
// - Low-voltage detection stops in stop modes unless its stop enable is set.
`timescale 1ns/1ps
module rirc_top #(
  parameter int TICK_CYCLES = rirc_pkg::INT_TICK_CYCLES
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic [7:0]          regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWrStrobe,
  input  wire logic                regRdStrobe,
  output logic      [7:0]          regRdData,
  input  wire logic                pinIrq,
  input  wire logic                extRefClk,
  input  wire logic                extResetN,
  input  wire logic                belowLvLow,
  input  wire logic                belowLvHigh,
  input  wire logic                belowWarnLow,
  input  wire logic                belowWarnHigh,
  input  wire rirc_pkg::rirc_mode_e opMode,
  input  wire logic                watchdogTimeout,
  input  wire logic                badOpcode,
  input  wire logic                stopInstr,
  input  wire logic                bgndInstr,
  input  wire logic                cpuAccess,
  input  wire logic [15:0]         cpuAddr,
  input  wire logic                clockModuleReset,
  input  wire logic                debugForceReset,
  output logic                     systemResetReq,
  output logic                     undervoltageIrq,
  output logic                     periodicIrq,
  output logic                     pinIrqReq,
  output logic                     watchdogRestart,
  output logic                     pinPullEnable,
  output logic                     pinPullDown
);
  import rirc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for everything that comes from outside the clock.

  localparam int NSYNC = 7;
  logic [NSYNC-1:0] asyncIn;
  logic [NSYNC-1:0] syncS1;
  logic [NSYNC-1:0] syncS2;
  logic [NSYNC-1:0] syncS3;
  logic [NSYNC-1:0] syncVal;

  assign asyncIn = {belowWarnHigh, belowWarnLow, belowLvHigh, belowLvLow,
                    extResetN, extRefClk, pinIrq};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        syncS1[gi] <= asyncIn[gi];
        syncS2[gi] <= syncS1[gi];
        syncS3[gi] <= syncS2[gi];
        // A change is taken only once the last two stages agree.
        // Reset preloads the output so a pin that never settles cannot leave it unknown.
        if (reset) begin
          syncVal[gi] <= syncS3[gi];
        end else if (syncS2[gi] == syncS3[gi]) begin
          syncVal[gi] <= syncS3[gi];
        end
      end
    end
  endgenerate

  logic pinLevel;
  logic refLevel;
  logic extRstLow;
  logic lvLow;
  logic lvHigh;
  logic warnLow;
  logic warnHigh;
  assign pinLevel  = syncVal[0];
  assign refLevel  = syncVal[1];
  assign extRstLow = ~syncVal[2];
  assign lvLow     = syncVal[3];
  assign lvHigh    = syncVal[4];
  assign warnLow   = syncVal[5];
  assign warnHigh  = syncVal[6];

  //////////////////////////////////////////////////////////////////////////////
  // Register write decode.

  logic wrPin;
  logic wrRst;
  logic wrRti;
  logic wrPwr1;
  logic wrPwr2;
  logic wrOpt;
  assign wrPin  = regWrStrobe && (regAddr == PIN_CTL_ADDR);
  assign wrRst  = regWrStrobe && (regAddr == RST_STAT_ADDR);
  assign wrRti  = regWrStrobe && (regAddr == RTI_CTL_ADDR);
  assign wrPwr1 = regWrStrobe && (regAddr == PWR_CTL1_ADDR);
  assign wrPwr2 = regWrStrobe && (regAddr == PWR_CTL2_ADDR);
  assign wrOpt  = regWrStrobe && (regAddr == SYS_OPT_ADDR);

  logic       pinPol_reg;
  logic       pinEn_reg;
  logic       pinIe_reg;
  logic       pinMode_reg;
  logic       rtiClkSel_reg;
  logic       rtiIe_reg;
  logic [2:0] rtiSel_reg;
  logic [7:0] pwr1_reg;
  logic [7:0] pwr2_reg;
  logic [7:0] sysOpt_reg;
  logic       optLocked_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinPol_reg    <= 1'b0;
      pinEn_reg     <= 1'b0;
      pinIe_reg     <= 1'b0;
      pinMode_reg   <= 1'b0;
      rtiClkSel_reg <= 1'b0;
      rtiIe_reg     <= 1'b0;
      rtiSel_reg    <= 3'h0;
      pwr1_reg      <= PWR_CTL1_RST;
      pwr2_reg      <= PWR_CTL2_RST;
      sysOpt_reg    <= SYS_OPT_RST;
      optLocked_reg <= 1'b0;
    end else begin
      if (wrPin) begin
        pinPol_reg  <= regWrData[PIN_POL_BIT];
        pinEn_reg   <= regWrData[PIN_EN_BIT];
        pinIe_reg   <= regWrData[PIN_IE_BIT];
        pinMode_reg <= regWrData[PIN_MODE_BIT];
      end
      if (wrRti) begin
        rtiClkSel_reg <= regWrData[RTI_CLKS_BIT];
        rtiIe_reg     <= regWrData[RTI_IE_BIT];
        rtiSel_reg    <= regWrData[2:0];
      end
      if (wrPwr1) begin
        pwr1_reg <= regWrData & 8'h38;
      end
      if (wrPwr2) begin
        pwr2_reg <= regWrData & 8'h38;
      end
      // Options are write-once so stray code cannot reopen stop or the watchdog.
      if (wrOpt && !optLocked_reg) begin
        sysOpt_reg    <= regWrData & 8'hB0;
        optLocked_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Undervoltage detection, warning and interrupt.

  logic lvBelowSel;
  logic lvDetActive;
  logic lvFlag_reg;
  assign lvBelowSel  = pwr2_reg[LV_TRIP_BIT] ? lvHigh : lvLow;
  assign lvDetActive = pwr1_reg[LV_DE_BIT] &&
                       ((opMode == RIRC_RUN) || pwr2_reg[LV_SE_BIT]);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lvFlag_reg <= 1'b0;
    end else if (lvDetActive && lvBelowSel) begin
      lvFlag_reg <= 1'b1;
    end else if (wrPwr1 && regWrData[LV_ACK_BIT]) begin
      lvFlag_reg <= 1'b0;
    end
  end

  // The warning follows the selected trip and has no request path at all.
  logic warnBelow;
  assign warnBelow = pwr2_reg[WARN_TRIP_BIT] ? warnHigh : warnLow;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      undervoltageIrq <= 1'b0;
    end else begin
      undervoltageIrq <= lvFlag_reg && pwr1_reg[LV_IE_BIT] &&
                         pwr1_reg[LV_DE_BIT] && !pwr1_reg[LV_RE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset sources, hold and status capture.

  logic causeLv;
  logic causeWdg;
  logic causeOpc;
  logic causeAdr;
  logic causeOther;
  logic anyCause;
  logic porHold_reg;
  logic lvHold_reg;
  logic [7:0] rstStat_reg;

  assign causeLv  = lvDetActive && pwr1_reg[LV_RE_BIT] && lvBelowSel;
  assign causeWdg = watchdogTimeout && sysOpt_reg[OPT_WDG_BIT];
  assign causeOpc = badOpcode || (stopInstr && !sysOpt_reg[OPT_STOP_BIT]) ||
                    (bgndInstr && !sysOpt_reg[OPT_BDM_BIT]);
  assign causeAdr = cpuAccess &&
                    (((cpuAddr >= GAP1_LO) && (cpuAddr <= GAP1_HI)) ||
                     ((cpuAddr >= GAP2_LO) && (cpuAddr <= GAP2_HI)));
  assign causeOther = extRstLow || causeWdg || causeOpc || causeAdr || clockModuleReset;
  assign anyCause   = causeLv || causeOther || debugForceReset;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      porHold_reg <= 1'b1;
    end else if (!lvLow) begin
      porHold_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lvHold_reg <= 1'b0;
    end else if (causeLv) begin
      lvHold_reg <= 1'b1;
    end else if (!lvBelowSel) begin
      lvHold_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      systemResetReq <= 1'b1;
    end else begin
      systemResetReq <= porHold_reg || lvHold_reg || anyCause;
    end
  end

  // Flags are taken only on the cycle reset begins, then frozen.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rstStat_reg <= RST_STAT_POR_VAL;
    end else if (anyCause && !systemResetReq) begin
      rstStat_reg <= 8'h00;
      if (causeLv) begin
        rstStat_reg[RST_POR_BIT] <= rstStat_reg[RST_POR_BIT];
        rstStat_reg[RST_LV_BIT]  <= 1'b1;
      end else if (causeOther) begin
        rstStat_reg[RST_PIN_BIT] <= extRstLow;
        rstStat_reg[RST_WDG_BIT] <= causeWdg;
        rstStat_reg[RST_OPC_BIT] <= causeOpc;
        rstStat_reg[RST_CLK_BIT] <= clockModuleReset;
      end
    end
  end

  // A write to the status address only kicks the watchdog.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      watchdogRestart <= 1'b0;
    end else begin
      watchdogRestart <= wrRst;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pin conditioning.

  logic pinAsserted;
  logic pinAssertedPrev_reg;
  logic pinEvent;
  logic pinFlag_reg;
  assign pinAsserted = (pinLevel == pinPol_reg);
  assign pinEvent    = pinEn_reg && ((pinAsserted && !pinAssertedPrev_reg) ||
                                     (pinMode_reg && pinAsserted));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinAssertedPrev_reg <= 1'b0;
    end else begin
      pinAssertedPrev_reg <= pinAsserted;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinFlag_reg <= 1'b0;
    end else if (pinEvent) begin
      pinFlag_reg <= 1'b1;
    end else if (wrPin && regWrData[PIN_ACK_BIT] && !(pinMode_reg && pinAsserted)) begin
      pinFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinIrqReq     <= 1'b0;
      pinPullEnable <= 1'b0;
      pinPullDown   <= 1'b0;
    end else begin
      pinIrqReq     <= pinFlag_reg && pinIe_reg;
      pinPullEnable <= pinEn_reg;
      pinPullDown   <= pinEn_reg && pinPol_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Periodic timer.

  logic        refPrev_reg;
  logic        useExt;
  logic        tickEn;
  logic [13:0] intDiv_reg;
  logic        intTick;
  logic [15:0] rtiCount_reg;
  logic [15:0] rtiLimit;
  logic        rtiStep;
  logic        rtiTimeout;
  logic        rtiFlag_reg;

  // Run allows only the reference clock, stop2 only the internal tick, stop1 neither; stop3 honours the select.
  always_comb begin
    useExt = 1'b0;
    tickEn = 1'b0;
    unique case (opMode)
      RIRC_RUN: begin
        useExt = 1'b1;
        tickEn = 1'b1;
      end
      RIRC_STOP1: begin
        useExt = 1'b0;
        tickEn = 1'b0;
      end
      RIRC_STOP2: begin
        useExt = 1'b0;
        tickEn = 1'b1;
      end
      RIRC_STOP3: begin
        useExt = rtiClkSel_reg;
        tickEn = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refPrev_reg <= 1'b0;
      intDiv_reg  <= 14'h0000;
    end else begin
      refPrev_reg <= refLevel;
      if (intTick) begin
        intDiv_reg <= 14'h0000;
      end else begin
        intDiv_reg <= intDiv_reg + 14'h0001;
      end
    end
  end
  assign intTick = (intDiv_reg == 14'(TICK_CYCLES - 1));

  always_comb begin
    rtiLimit = 16'h0000;
    unique case (rtiSel_reg)
      3'h0: rtiLimit = 16'h0000;
      3'h1: rtiLimit = useExt ? 16'h00FF : 16'h0007;
      3'h2: rtiLimit = useExt ? 16'h03FF : 16'h001F;
      3'h3: rtiLimit = useExt ? 16'h07FF : 16'h003F;
      3'h4: rtiLimit = useExt ? 16'h0FFF : 16'h007F;
      3'h5: rtiLimit = useExt ? 16'h1FFF : 16'h00FF;
      3'h6: rtiLimit = useExt ? 16'h3FFF : 16'h01FF;
      3'h7: rtiLimit = useExt ? 16'h7FFF : 16'h03FF;
    endcase
  end

  assign rtiStep    = tickEn && (useExt ? (refLevel && !refPrev_reg) : intTick);
  assign rtiTimeout = rtiStep && (rtiSel_reg != 3'h0) && (rtiCount_reg >= rtiLimit);

  always_ff @(posedge sys_clk) begin
    if (reset || rtiSel_reg == 3'h0) begin
      rtiCount_reg <= 16'h0000;
    end else if (rtiTimeout) begin
      rtiCount_reg <= 16'h0000;
    end else if (rtiStep) begin
      rtiCount_reg <= rtiCount_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rtiFlag_reg <= 1'b0;
    end else if (rtiTimeout) begin
      rtiFlag_reg <= 1'b1;
    end else if (wrRti && regWrData[RTI_ACK_BIT]) begin
      rtiFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      periodicIrq <= 1'b0;
    end else begin
      periodicIrq <= rtiFlag_reg && rtiIe_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read, acknowledge bits always read zero.

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRdStrobe) begin
      unique case (regAddr)
        PIN_CTL_ADDR:  regRdData <= {2'b00, pinPol_reg, pinEn_reg, pinFlag_reg, 1'b0,
                                     pinIe_reg, pinMode_reg};
        RST_STAT_ADDR: regRdData <= rstStat_reg;
        RTI_CTL_ADDR:  regRdData <= {rtiFlag_reg, 1'b0, rtiClkSel_reg, rtiIe_reg, 1'b0,
                                     rtiSel_reg};
        PWR_CTL1_ADDR: regRdData <= {lvFlag_reg, pwr1_reg[6:0]};
        PWR_CTL2_ADDR: regRdData <= {warnBelow, pwr2_reg[6:0]};
        SYS_OPT_ADDR:  regRdData <= sysOpt_reg;
        default:       regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_por_flags;
    @(posedge sys_clk) reset |=> (rstStat_reg == RST_STAT_POR_VAL) && systemResetReq;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_lv_hold;
    @(posedge sys_clk) disable iff (reset) lvHold_reg && lvBelowSel |=> systemResetReq;
  endproperty
  a_lv_hold: assert property (p_lv_hold) else $error("low-voltage hold dropped");

  property p_pin_edge;
    @(posedge sys_clk) disable iff (reset)
      pinEn_reg && pinAsserted && !pinAssertedPrev_reg |=> pinFlag_reg ##1 pinFlag_reg || wrPin;
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("pin edge not flagged");

  property p_pin_level;
    @(posedge sys_clk) disable iff (reset)
      pinEn_reg && pinMode_reg && pinAsserted && wrPin && regWrData[PIN_ACK_BIT] |=> pinFlag_reg;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("flag cleared at asserted level");

  property p_pin_off;
    @(posedge sys_clk) disable iff (reset) !pinEn_reg && !pinFlag_reg |=> !pinFlag_reg;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin set flag");

  property p_ack_zero;
    @(posedge sys_clk) disable iff (reset)
      regRdStrobe && (regAddr == PIN_CTL_ADDR) |=> !regRdData[PIN_ACK_BIT];
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("acknowledge bit read back");

  property p_rti_ack_zero;
    @(posedge sys_clk) disable iff (reset)
      regRdStrobe && (regAddr == RTI_CTL_ADDR) |=> !regRdData[RTI_ACK_BIT];
  endproperty
  a_rti_ack_zero: assert property (p_rti_ack_zero) else $error("timer ack read back");

  property p_wdg_kick;
    @(posedge sys_clk) disable iff (reset)
      wrRst && !anyCause |=> watchdogRestart && $stable(rstStat_reg);
  endproperty
  a_wdg_kick: assert property (p_wdg_kick) else $error("status write misbehaved");

  property p_debug_clear;
    @(posedge sys_clk) disable iff (reset)
      debugForceReset && !causeLv && !causeOther && !systemResetReq |=> rstStat_reg == 8'h00;
  endproperty
  a_debug_clear: assert property (p_debug_clear) else $error("debug reset left flags");

  property p_rti_off;
    @(posedge sys_clk) disable iff (reset) rtiSel_reg == 3'h0 |=> !rtiTimeout ##1 !rtiTimeout;
  endproperty
  a_rti_off: assert property (p_rti_off) else $error("timer ran while disabled");

  property p_rti_irq;
    @(posedge sys_clk) disable iff (reset) periodicIrq |-> $past(rtiFlag_reg) && $past(rtiIe_reg);
  endproperty
  a_rti_irq: assert property (p_rti_irq) else $error("timer request without enable");

  property p_pull;
    @(posedge sys_clk) disable iff (reset) pinPullDown |-> pinPullEnable;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-down without enable");
endmodule

// ===== tb/rirc_pin_src.sv
// Partner model of the source that drives the interrupt pin.
`timescale 1ns/1ps
module rirc_pin_src (
  input  wire logic sys_clk,
  input  wire logic pullEn,
  input  wire logic pullDown,
  output logic      pinIrq
);
  logic drv = 1'h0;
  logic lvl = 1'h0;
  initial pinIrq = 1'h0;
  // An undriven line with no pull wanders, so a stale level is never trusted.
  always @(posedge sys_clk) pinIrq <= drv ? lvl : pullEn ? !pullDown : !pinIrq;
  task automatic drive(input logic v, input int d);
    repeat (d) @(posedge sys_clk);
    lvl <= v;
    drv <= 1'h1;
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the reset, interrupt pin and periodic timer block.
`timescale 1ns/1ps
module tb_top;
  import rirc_pkg::*;
  localparam int TICK = 10;
  logic        sys_clk = 1'h0, reset = 1'h1, regWrStrobe = 1'h0, regRdStrobe = 1'h0;
  logic        extRefClk = 1'h0, belowLvLow = 1'h0, belowWarnLow = 1'h0, extResetN = 1'h1;
  logic        watchdogTimeout = 1'h0, badOpcode = 1'h0, stopInstr = 1'h0;
  logic        clockModuleReset = 1'h0, debugForceReset = 1'h0, cpuAccess = 1'h0;
  logic        bgndInstr = 1'h0, belowLvHigh = 1'h0, belowWarnHigh = 1'h0;
  logic        pinIrq, systemResetReq, undervoltageIrq, periodicIrq;
  logic        pinIrqReq, watchdogRestart, pinPullEnable, pinPullDown;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [15:0] cpuAddr = 16'h1800;
  rirc_mode_e  opMode = RIRC_RUN;
  int          num_errors = 0, comparisons = 0, wdgPulses = 0, n, e, seed = 1624;
  logic [7:0]  stExp [9] = '{8'h82, 8'h20, 8'h10, 8'h10, 8'h04, 8'h00, 8'h40, 8'h00, 8'h10};
  wire logic [3:0] outs = {systemResetReq, undervoltageIrq, periodicIrq, pinIrqReq};
  rirc_top #(.TICK_CYCLES(TICK)) rirc_top_inst (.sys_clk, .reset, .regAddr, .regWrData,
    .regWrStrobe, .regRdStrobe, .regRdData, .pinIrq, .extRefClk, .extResetN, .belowLvLow,
    .belowLvHigh, .belowWarnLow, .belowWarnHigh, .opMode, .watchdogTimeout,
    .badOpcode, .stopInstr, .bgndInstr, .cpuAccess, .cpuAddr, .clockModuleReset,
    .debugForceReset, .systemResetReq, .undervoltageIrq, .periodicIrq, .pinIrqReq,
    .watchdogRestart, .pinPullEnable, .pinPullDown);
  rirc_pin_src rirc_pin_src_inst (.sys_clk, .pullEn(pinPullEnable), .pullDown(pinPullDown),
    .pinIrq);
  always #50 sys_clk = ~sys_clk;
  always #200 extRefClk = ~extRefClk;
  always @(posedge sys_clk) if (watchdogRestart === 1'h1) wdgPulses++;
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'h1;
    @(posedge sys_clk);
    regWrStrobe <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStrobe <= 1'h1;
    @(posedge sys_clk);
    regRdStrobe <= 1'h0;
    #1 chk(nm, {8'h00, x}, {8'h00, regRdData});
  endtask
  // A bound that runs out ends the run at once rather than letting it hang.
  task automatic waitBit(input int b, input logic v, input int lim);
    n = 0;
    while (outs[b] !== v) begin
      @(posedge sys_clk);
      #1 n++;
      if (n > lim) begin
        num_errors++;
        end_of_test();
      end
    end
  endtask
  task automatic src(input int k, input logic v);
    @(posedge sys_clk);
    case (k)
      0: belowLvLow <= v;
      1: watchdogTimeout <= v;
      2: badOpcode <= v;
      3: stopInstr <= v;
      4: clockModuleReset <= v;
      5: debugForceReset <= v;
      6: extResetN <= !v;
      7: cpuAccess <= v;
      default: bgndInstr <= v;
    endcase
  endtask
  task automatic rti(input int s, input int cyc);
    wr(RTI_CTL_ADDR, 8'h40);
    wr(RTI_CTL_ADDR, 8'(16 + s));
    waitBit(1, 1'h1, cyc + 40);
    chk("rtiCycles", 16'(cyc), 16'((n > cyc - 12 && n < cyc + 12) ? cyc : n));
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'h0;
    waitBit(3, 1'h0, 10);
    rd(RST_STAT_ADDR, RST_STAT_POR_VAL, "status");
    rd(PWR_CTL1_ADDR, PWR_CTL1_RST, "power1");
    rd(8'h10, 8'h00, "unmapped");
    wr(RST_STAT_ADDR, 8'($random(seed)));
    repeat (3) @(posedge sys_clk);
    chk("wdgPulse", 16'h0001, 16'(wdgPulses));
    rd(RST_STAT_ADDR, RST_STAT_POR_VAL, "status");
    src(7, 1'h1);
    repeat (8) @(posedge sys_clk);
    chk("sysReset", 16'h0000, 16'(systemResetReq));
    src(7, 1'h0);
    cpuAddr <= 16'h0440;
    for (int k = 0; k < 9; k++) begin
      src(k, 1'h1);
      waitBit(3, 1'h1, 10);
      repeat (6) @(posedge sys_clk);
      src(k, 1'h0);
      waitBit(3, 1'h0, 20);
      rd(RST_STAT_ADDR, stExp[k], "status");
    end
    wr(PIN_CTL_ADDR, 8'h32);
    repeat (5) @(posedge sys_clk);
    chk("pull", 16'h0003, 16'({pinPullEnable, pinPullDown}));
    rirc_pin_src_inst.drive(1'h1, $random(seed) & 7);
    waitBit(0, 1'h1, 12);
    rd(PIN_CTL_ADDR, 8'h3A, "pinCtl");
    wr(PIN_CTL_ADDR, 8'h36);
    rd(PIN_CTL_ADDR, 8'h32, "pinCtl");
    chk("pinReq", 16'h0000, 16'(pinIrqReq));
    wr(PIN_CTL_ADDR, 8'h37);
    rd(PIN_CTL_ADDR, 8'h3B, "pinCtl");
    wr(PIN_CTL_ADDR, 8'h16);
    rd(PIN_CTL_ADDR, 8'h1A, "pinCtl");
    wr(PIN_CTL_ADDR, 8'h16);
    rd(PIN_CTL_ADDR, 8'h12, "pinCtl");
    chk("pull", 16'h0002, 16'({pinPullEnable, pinPullDown}));
    rirc_pin_src_inst.drive(1'h0, $random(seed) & 7);
    waitBit(0, 1'h1, 12);
    wr(PIN_CTL_ADDR, 8'h06);
    rirc_pin_src_inst.drive(1'h1, 4);
    rirc_pin_src_inst.drive(1'h0, 4);
    repeat (8) @(posedge sys_clk);
    rd(PIN_CTL_ADDR, 8'h02, "pinCtl");
    @(posedge sys_clk) opMode <= RIRC_STOP2;
    for (int s = 1; s < 8; s++) rti(s, TICK * ((s == 1) ? 8 : 16 << (s - 1)));
    wr(RTI_CTL_ADDR, 8'h41);
    rd(RTI_CTL_ADDR, 8'h01, "rtiCtl");
    repeat (120) @(posedge sys_clk);
    rd(RTI_CTL_ADDR, 8'h81, "rtiCtl");
    chk("rtiReq", 16'h0000, 16'(periodicIrq));
    wr(RTI_CTL_ADDR, 8'h50);
    repeat (150) @(posedge sys_clk);
    chk("rtiReq", 16'h0000, 16'(periodicIrq));
    @(posedge sys_clk) opMode <= RIRC_STOP1;
    wr(RTI_CTL_ADDR, 8'h11);
    repeat (150) @(posedge sys_clk);
    chk("rtiReq", 16'h0000, 16'(periodicIrq));
    @(posedge sys_clk) opMode <= RIRC_STOP3;
    rti(1, TICK * 8);
    @(posedge sys_clk) opMode <= RIRC_RUN;
    rti(1, 1024);
    wr(PWR_CTL1_ADDR, 8'h28);
    src(0, 1'h1);
    waitBit(2, 1'h1, 10);
    rd(PWR_CTL1_ADDR, 8'hA8, "power1");
    chk("sysReset", 16'h0000, 16'(systemResetReq));
    @(posedge sys_clk) belowWarnLow <= 1'h1;
    repeat (5) @(posedge sys_clk);
    rd(PWR_CTL2_ADDR, 8'h80, "power2");
    wr(PWR_CTL2_ADDR, 8'h18);
    wr(PWR_CTL1_ADDR, 8'h68);
    rd(PWR_CTL1_ADDR, 8'h28, "power1");
    rd(PWR_CTL2_ADDR, 8'h18, "power2");
    @(posedge sys_clk) {belowLvHigh, belowWarnHigh} <= 2'h3;
    repeat (5) @(posedge sys_clk);
    rd(PWR_CTL1_ADDR, 8'hA8, "power1");
    rd(PWR_CTL2_ADDR, 8'h98, "power2");
    @(posedge sys_clk) opMode <= RIRC_STOP2;
    wr(PWR_CTL1_ADDR, 8'h68);
    rd(PWR_CTL1_ADDR, 8'h28, "power1");
    end_of_test();
  end
endmodule
